//--- ascra_pkg.sv
// Functional notes
// R1 - status bits 15..10 always read zero
// R2 - status bits 9..8 show power setting
// R3 - status bits 7..6 always read one
// R4 - status bit 5 shows bipolar range
// R5 - status bit 4 busy converting or calibrating
// R6 - status bit 3 shows system calibration kind
// R7 - status bit 0 set while calibrating
// R8 - status bits 2..1 echo set selection
// R9 - ten coefficient registers, host read/write
// R10 - calibration updates coefficients without host
// R11 - set selection picks accessible coefficient subset
// R12 - host never mixes reads and writes
// R13 - host selects calibration readback before reading
// R14 - pointer rewinds on control write, wrap
// R15 - reset pointer on gain, offset-only excepted
// R16 - pointer steps after full word access
// R17 - host sends low byte before high
// R18 - abandoned sequences rewind at next control
// R19 - coefficient reads show two zero MSBs
// R20 - host selects status readback before reading
// R21 - full set order: gain, offset, dac0..7
package ascra_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int COEF_W = 14;
  localparam int NUM_COEF = 10;
  localparam int PTR_W = 4;
  // control word field positions
  localparam int CTL_PWR_LO = 8;
  localparam int CTL_RDSEL_LO = 6;
  localparam int CTL_RANGE = 5;
  localparam int CTL_CONV = 4;
  localparam int CTL_CALKIND = 3;
  localparam int CTL_CALSET_LO = 1;
  localparam int CTL_CALRUN = 0;
  // status word constant fields and coefficient read padding
  localparam logic [5:0] ST_ZERO_FIELD = 6'h00;
  localparam logic [1:0] ST_ONE_FIELD = 2'h3;
  localparam logic [1:0] COEF_PAD = 2'h0;
  // readback targets
  localparam logic [1:0] RDSEL_CAL = 2'h2;
  localparam logic [1:0] RDSEL_STATUS = 2'h3;
  // coefficient set selections
  localparam logic [1:0] CALSET_ALL = 2'h0;
  localparam logic [1:0] CALSET_GAIN_OFS = 2'h1;
  localparam logic [1:0] CALSET_OFS = 2'h2;
  localparam logic [1:0] CALSET_GAIN = 2'h3;
  // coefficient indices in stepping order
  localparam logic [3:0] IDX_GAIN = 4'h0;
  localparam logic [3:0] IDX_OFS = 4'h1;
  localparam logic [3:0] IDX_LAST = 4'h9;
  // reset values
  localparam logic [1:0] PWR_RST = 2'h0;
  localparam logic [1:0] RDSEL_RST = 2'h0;
  localparam logic [1:0] CALSET_RST = 2'h0;
  localparam logic [13:0] COEF_RST = 14'h0000;
  typedef enum logic [1:0] {ASCRA_IDLE, ASCRA_LOW, ASCRA_HOLD, ASCRA_GAP} ascra_host_st_t;
endpackage

//--- ascra_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ascra_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic wr_to_cal;
  logic upper_byte_select;
  logic byte_mode;
  logic [15:0] h_d_out;
  logic h_d_oe;
  logic [15:0] d_d_out;
  logic d_d_oe;
  logic [15:0] data;
  // shared data wire; device wins if both drive
  assign data = d_d_oe ? d_d_out : (h_d_oe ? h_d_out : 16'h0000);
  modport dev (
    input cs_n, rd_n, wr_n, wr_to_cal, upper_byte_select, byte_mode, data,
    output d_d_out, d_d_oe
  );
  modport host (
    input data,
    output cs_n, rd_n, wr_n, wr_to_cal, upper_byte_select, byte_mode, h_d_out, h_d_oe
  );
endinterface
`default_nettype wire

//--- ascra_host.sv
`timescale 1ns/100ps
`default_nettype none
module ascra_host (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // parallel port
  ascra_if.host PORT,
  // strap, held static
  input wire logic BYTE_MODE,
  // command port
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_WRITE,
  input wire logic CMD_TO_CAL,
  input wire logic [15:0] CMD_DATA,
  // answer port
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA
);
  typedef struct packed {
    ascra_pkg::ascra_host_st_t st;
    logic upper;
    logic wr;
    logic to_cal;
    logic [15:0] word;
    logic [15:0] dout;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } ascra_host_state_t;

  ascra_host_state_t cur_reg, cur_next;
  logic active;

  assign active = (cur_reg.st == ascra_pkg::ASCRA_LOW) || (cur_reg.st == ascra_pkg::ASCRA_HOLD);
  assign PORT.cs_n = !active;
  assign PORT.rd_n = !(active && !cur_reg.wr);
  assign PORT.wr_n = !(active && cur_reg.wr);
  assign PORT.wr_to_cal = cur_reg.to_cal;
  assign PORT.upper_byte_select = cur_reg.upper;
  assign PORT.byte_mode = BYTE_MODE;
  assign PORT.h_d_out = cur_reg.dout;
  assign PORT.h_d_oe = active && cur_reg.wr;
  assign CMD_READY = (cur_reg.st == ascra_pkg::ASCRA_IDLE);
  assign RSP_VALID = cur_reg.rsp_valid;
  assign RSP_DATA = cur_reg.rsp_data;

  always_comb begin
    cur_next = cur_reg;
    cur_next.rsp_valid = 1'b0;
    case (cur_reg.st)
      ascra_pkg::ASCRA_IDLE: begin
        // one command at a time keeps reads and writes apart
        if (CMD_VALID) begin // R12
          cur_next.wr = CMD_WRITE;
          cur_next.to_cal = CMD_TO_CAL;
          cur_next.word = CMD_DATA;
          cur_next.rsp_data = 16'h0000;
          cur_next.upper = !BYTE_MODE; // R17
          cur_next.dout = BYTE_MODE ? {8'h00, CMD_DATA[7:0]} : CMD_DATA; // R17
          cur_next.st = ascra_pkg::ASCRA_LOW;
        end
      end
      ascra_pkg::ASCRA_LOW: begin
        cur_next.st = ascra_pkg::ASCRA_HOLD;
      end
      ascra_pkg::ASCRA_HOLD: begin
        if (!cur_reg.wr) begin
          if (!BYTE_MODE) begin
            cur_next.rsp_data = PORT.data;
          end else if (cur_reg.upper) begin
            cur_next.rsp_data[15:8] = PORT.data[7:0];
          end else begin
            cur_next.rsp_data[7:0] = PORT.data[7:0];
          end
        end
        cur_next.st = ascra_pkg::ASCRA_GAP;
      end
      ascra_pkg::ASCRA_GAP: begin
        if (BYTE_MODE && !cur_reg.upper) begin
          cur_next.upper = 1'b1; // R17
          cur_next.dout = {8'h00, cur_reg.word[15:8]};
          cur_next.st = ascra_pkg::ASCRA_LOW;
        end else begin
          cur_next.rsp_valid = 1'b1;
          cur_next.st = ascra_pkg::ASCRA_IDLE;
        end
      end
      default: begin
        cur_next.st = ascra_pkg::ASCRA_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end
endmodule
`default_nettype wire

//--- ascra_dev.sv
`timescale 1ns/100ps
`default_nettype none
module ascra_dev #(
  parameter int RESULT_W = 12
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // parallel port
  ascra_if.dev PORT,
  // converter engine status
  input wire logic CONV_BUSY,
  input wire logic [RESULT_W-1:0] CONV_RESULT,
  // calibration engine
  input wire logic CAL_DONE,
  input wire logic CAL_WR_EN,
  input wire logic [3:0] CAL_WR_IDX,
  input wire logic [13:0] CAL_WR_DATA,
  // control towards the engines
  output logic START_CONV,
  output logic START_CAL,
  output logic [1:0] PWR_LEVEL,
  output logic RANGE_BIPOLAR,
  output logic CAL_KIND_SYSTEM,
  output logic [1:0] CAL_SET,
  // coefficients, index 0 gain, 1 offset, 2..9 dac
  output logic [ascra_pkg::NUM_COEF*ascra_pkg::COEF_W-1:0] COEFS
);
  typedef struct packed {
    logic [1:0] power_level_sel;
    logic [1:0] readback_target;
    logic input_range_bipolar;
    logic cal_kind_system;
    logic [1:0] cal_set_sel;
    logic cal_run_flag;
    logic conv_go;
    logic cal_go;
    logic [3:0] ptr;
    logic [7:0] lo_stage;
    logic [15:0] rd_data;
    logic acc_prev;
    logic [ascra_pkg::NUM_COEF-1:0][ascra_pkg::COEF_W-1:0] coef;
  } ascra_dev_state_t;

  ascra_dev_state_t cur_reg, cur_next;
  logic acc;
  logic start;
  logic wr_take;
  logic rd_take;
  logic full_word;
  logic busy;
  logic [15:0] wword;
  logic [15:0] status_word;
  logic [15:0] rd_word;

  // offset-only is the one set that does not open on gain
  function automatic logic [3:0] set_first(input logic [1:0] sel);
    case (sel)
      ascra_pkg::CALSET_OFS: set_first = ascra_pkg::IDX_OFS; // R15
      default: set_first = ascra_pkg::IDX_GAIN; // R15
    endcase
  endfunction

  function automatic logic [3:0] set_last(input logic [1:0] sel);
    case (sel) // R11
      ascra_pkg::CALSET_ALL: set_last = ascra_pkg::IDX_LAST;
      ascra_pkg::CALSET_GAIN_OFS: set_last = ascra_pkg::IDX_OFS;
      ascra_pkg::CALSET_OFS: set_last = ascra_pkg::IDX_OFS;
      default: set_last = ascra_pkg::IDX_GAIN;
    endcase
  endfunction

  // wraps to the set's first entry once the last one is done
  function automatic logic [3:0] step_ptr(input logic [3:0] p, input logic [1:0] sel);
    if (p == set_last(sel)) begin
      step_ptr = set_first(sel); // R14
    end else begin
      step_ptr = p + 4'h1; // R21
    end
  endfunction

  // byte reads carry their half of the word on the low lane
  function automatic logic [15:0] rd_lane(input logic [15:0] w, input logic bm, input logic up);
    if (!bm) begin
      rd_lane = w;
    end else if (up) begin
      rd_lane = {8'h00, w[15:8]};
    end else begin
      rd_lane = {8'h00, w[7:0]};
    end
  endfunction

  assign busy = CONV_BUSY || cur_reg.cal_run_flag; // R5
  // status is assembled live, so it never lags the fields it shows
  assign status_word = {
    ascra_pkg::ST_ZERO_FIELD, // R1
    cur_reg.power_level_sel, // R2
    ascra_pkg::ST_ONE_FIELD, // R3
    cur_reg.input_range_bipolar, // R4
    busy,
    cur_reg.cal_kind_system, // R6
    cur_reg.cal_set_sel, // R8
    cur_reg.cal_run_flag // R7
  };

  // strobes are sampled; a transfer is taken once, on the first low cycle
  // no error flag: misordered host accesses are simply taken as they come
  assign acc = !PORT.cs_n && (!PORT.rd_n || !PORT.wr_n);
  assign start = acc && !cur_reg.acc_prev;
  assign wr_take = start && !PORT.wr_n;
  assign rd_take = start && !PORT.rd_n && PORT.wr_n;
  // in byte mode only the high byte completes a word
  assign full_word = !PORT.byte_mode || PORT.upper_byte_select; // R16
  assign wword = PORT.byte_mode ? {PORT.data[7:0], cur_reg.lo_stage} : PORT.data;

  // targets 00 and 01 both return the latest result
  always_comb begin
    case (cur_reg.readback_target)
      ascra_pkg::RDSEL_STATUS: rd_word = status_word;
      ascra_pkg::RDSEL_CAL: rd_word = {ascra_pkg::COEF_PAD, cur_reg.coef[cur_reg.ptr]}; // R19
      default: rd_word = {{(16-RESULT_W){1'b0}}, CONV_RESULT};
    endcase
  end

  always_comb begin
    cur_next = cur_reg;
    cur_next.conv_go = 1'b0;
    cur_next.cal_go = 1'b0;
    cur_next.acc_prev = acc;
    // clear first so a start in the same cycle wins
    if (CAL_DONE) begin
      cur_next.cal_run_flag = 1'b0;
    end
    if (wr_take) begin
      if (!full_word) begin
        // a lone high byte pairs with whatever low byte was staged last
        cur_next.lo_stage = PORT.data[7:0];
      end else if (!PORT.wr_to_cal) begin
        // power bits are only held and echoed; the engines act on them
        cur_next.power_level_sel = wword[ascra_pkg::CTL_PWR_LO +: 2];
        cur_next.readback_target = wword[ascra_pkg::CTL_RDSEL_LO +: 2];
        cur_next.input_range_bipolar = wword[ascra_pkg::CTL_RANGE];
        cur_next.cal_kind_system = wword[ascra_pkg::CTL_CALKIND];
        cur_next.cal_set_sel = wword[ascra_pkg::CTL_CALSET_LO +: 2];
        // any control write also ends an abandoned sequence
        cur_next.ptr = set_first(wword[ascra_pkg::CTL_CALSET_LO +: 2]); // R14 R18
        if (wword[ascra_pkg::CTL_CALRUN]) begin
          cur_next.cal_run_flag = 1'b1; // R7
          cur_next.cal_go = 1'b1;
        end
        if (wword[ascra_pkg::CTL_CONV]) begin
          cur_next.conv_go = 1'b1;
        end
      end else begin
        cur_next.coef[cur_reg.ptr] = wword[ascra_pkg::COEF_W-1:0]; // R9
        cur_next.ptr = step_ptr(cur_reg.ptr, cur_reg.cal_set_sel); // R16
      end
    end
    if (rd_take) begin
      cur_next.rd_data = rd_lane(rd_word, PORT.byte_mode, PORT.upper_byte_select);
      if (full_word && (cur_reg.readback_target == ascra_pkg::RDSEL_CAL)) begin
        cur_next.ptr = step_ptr(cur_reg.ptr, cur_reg.cal_set_sel); // R16
      end
    end
    // while it runs, an engine write beats a host write to the same coefficient in that cycle
    // indices above the last coefficient are dropped, not wrapped
    if (cur_reg.cal_run_flag && CAL_WR_EN && (CAL_WR_IDX <= ascra_pkg::IDX_LAST)) begin
      cur_next.coef[CAL_WR_IDX] = CAL_WR_DATA; // R10
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cur_reg.power_level_sel <= ascra_pkg::PWR_RST;
      cur_reg.readback_target <= ascra_pkg::RDSEL_RST;
      cur_reg.input_range_bipolar <= 1'b0;
      cur_reg.cal_kind_system <= 1'b0;
      cur_reg.cal_set_sel <= ascra_pkg::CALSET_RST;
      cur_reg.cal_run_flag <= 1'b0;
      cur_reg.conv_go <= 1'b0;
      cur_reg.cal_go <= 1'b0;
      cur_reg.ptr <= ascra_pkg::IDX_GAIN; // R15
      cur_reg.lo_stage <= 8'h00;
      cur_reg.rd_data <= 16'h0000;
      cur_reg.acc_prev <= 1'b0;
      // coefficients clear to zero; the engine loads real values when it runs
      cur_reg.coef <= {ascra_pkg::NUM_COEF{ascra_pkg::COEF_RST}};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign PORT.d_d_out = cur_reg.rd_data;
  assign PORT.d_d_oe = !PORT.cs_n && !PORT.rd_n && PORT.wr_n;
  assign START_CONV = cur_reg.conv_go;
  assign START_CAL = cur_reg.cal_go;
  assign PWR_LEVEL = cur_reg.power_level_sel;
  assign RANGE_BIPOLAR = cur_reg.input_range_bipolar;
  assign CAL_KIND_SYSTEM = cur_reg.cal_kind_system;
  assign CAL_SET = cur_reg.cal_set_sel;
  // one slice per coefficient, gain in the lowest slice
  genvar gi;
  generate
    for (gi = 0; gi < ascra_pkg::NUM_COEF; gi++) begin : g_coef
      assign COEFS[gi*ascra_pkg::COEF_W +: ascra_pkg::COEF_W] = cur_reg.coef[gi];
    end
  endgenerate
endmodule
`default_nettype wire

//--- ascra_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ascra_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // link signals
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic wr_to_cal,
  input wire logic byte_mode,
  input wire logic h_d_oe,
  input wire logic d_d_oe,
  input wire logic [15:0] h_d_out,
  input wire logic [15:0] data
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence s_sel;
    $fell(cs_n);
  endsequence
  sequence s_xfer;
    !cs_n ##1 !cs_n ##1 cs_n;
  endsequence
  property p_xfer;
    s_sel |-> s_xfer;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer length wrong");
  property p_rd_oe;
    d_d_oe == (!cs_n && !rd_n && wr_n);
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("device drive wrong");
  property p_one_drv;
    !(d_d_oe && h_d_oe);
  endproperty
  a_one_drv: assert property (p_one_drv) else $error("bus contention");
  property p_h_oe;
    h_d_oe |-> !cs_n && !wr_n;
  endproperty
  a_h_oe: assert property (p_h_oe) else $error("host drives outside write");
  property p_rd_top;
    d_d_oe && $past(d_d_oe) && !byte_mode |-> data[15:14] == 2'h0;
  endproperty
  a_rd_top: assert property (p_rd_top) else $error("read top bits not zero");
  property p_wdata;
    h_d_oe && $past(h_d_oe) |-> $stable(h_d_out);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data moved");
  property p_ctl;
    !cs_n && !$past(cs_n) |-> $stable(wr_to_cal) && $stable(rd_n) && $stable(wr_n);
  endproperty
  a_ctl: assert property (p_ctl) else $error("qualifiers moved");
  property p_idle;
    cs_n |-> rd_n && wr_n;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe while deselected");
  property p_dir;
    rd_n || wr_n;
  endproperty
  a_dir: assert property (p_dir) else $error("read and write together");
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic conv_busy = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic cal_done = 1'b0;
  logic cal_wr_en = 1'b0;
  logic [3:0] cal_wr_idx = 4'h0;
  logic [13:0] cal_wr_data = 14'h0000;
  logic byte_mode = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_to_cal = 1'b0;
  logic [15:0] cmd_data = 16'h0000;
  logic cmd_ready, rsp_valid, start_conv, start_cal, range_bipolar, cal_kind_system;
  logic [15:0] rsp_data;
  logic [1:0] pwr_level, cal_set;
  logic [139:0] coefs;
  logic [15:0] exp_q[$];
  logic [15:0] v[10];
  logic [15:0] c;
  int err_count = 0;
  int tests_run = 0;
  int n_cal = 0;
  int n_conv = 0;
  ascra_if bus ();
  ascra_host i_ascra_host (.CLK(CLK), .SYS_RST(SYS_RST), .PORT(bus.host), .BYTE_MODE(byte_mode),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write),
    .CMD_TO_CAL(cmd_to_cal), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
  ascra_dev i_ascra_dev (.CLK(CLK), .SYS_RST(SYS_RST), .PORT(bus.dev), .CONV_BUSY(conv_busy),
    .CONV_RESULT(conv_result), .CAL_DONE(cal_done), .CAL_WR_EN(cal_wr_en),
    .CAL_WR_IDX(cal_wr_idx), .CAL_WR_DATA(cal_wr_data), .START_CONV(start_conv),
    .START_CAL(start_cal), .PWR_LEVEL(pwr_level), .RANGE_BIPOLAR(range_bipolar),
    .CAL_KIND_SYSTEM(cal_kind_system), .CAL_SET(cal_set), .COEFS(coefs));
  ascra_monitor i_ascra_monitor (.CLK(CLK), .SYS_RST(SYS_RST), .cs_n(bus.cs_n),
    .rd_n(bus.rd_n), .wr_n(bus.wr_n), .wr_to_cal(bus.wr_to_cal), .byte_mode(bus.byte_mode),
    .h_d_oe(bus.h_d_oe), .d_d_oe(bus.d_d_oe), .h_d_out(bus.h_d_out), .data(bus.data));
  initial forever #5 CLK = ~CLK;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // blocking command: returns once its answer has been checked
  task automatic cmd(input logic w, input logic t, input logic [15:0] d, input logic [15:0] e);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_to_cal <= t;
    cmd_data <= d;
    @(posedge CLK);
    while (cmd_ready !== 1'b1) @(posedge CLK);
    exp_q.push_back(e);
    cmd_valid <= 1'b0;
    do @(posedge CLK); while (exp_q.size() != 0);
  endtask
  always @(posedge CLK) begin
    if (rsp_valid === 1'b1) chk("rsp", rsp_data, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    if (start_cal === 1'b1) n_cal++;
    if (start_conv === 1'b1) n_conv++;
  end
  initial begin
    #100us;
    err_count++;
    end_sim();
  end
  initial begin
    int n, x;
    void'($urandom(32'hc633));
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    conv_result <= 12'($urandom);
    @(posedge CLK);
    // readback target is 00 after reset: conversion word
    cmd(1'b0, 1'b0, 16'h0000, {4'h0, conv_result});
    c = 16'($urandom);
    cmd(1'b1, 1'b1, c, 16'h0000);
    chk("gain", {2'h0, coefs[13:0]}, {2'h0, c[13:0]});
    for (int i = 0; i < 6; i++) begin
      c = (16'($urandom) & 16'h032e) | 16'h00c0;
      conv_busy <= 1'($urandom);
      cmd(1'b1, 1'b0, c, 16'h0000);
      cmd(1'b0, 1'b0, 16'h0000, c | {11'h0, conv_busy, 4'h0});
      chk("pwr", {14'h0, pwr_level}, {14'h0, c[9:8]});
      chk("ctl", {12'h0, range_bipolar, cal_kind_system, cal_set}, {12'h0, c[5], c[3], c[2:1]});
    end
    conv_busy <= 1'b0;
    cmd(1'b1, 1'b0, 16'h00d0, 16'h0000);
    chk("start_conv", 16'(n_conv), 16'h0001);
    cmd(1'b1, 1'b0, 16'h00c1, 16'h0000);
    cmd(1'b0, 1'b0, 16'h0000, 16'h00d1);
    chk("start_cal", 16'(n_cal), 16'h0001);
    v[0] = 16'($urandom);
    cal_wr_en <= 1'b1;
    cal_wr_idx <= 4'h5;
    cal_wr_data <= v[0][13:0];
    @(posedge CLK);
    cal_wr_en <= 1'b0;
    cal_done <= 1'b1;
    @(posedge CLK);
    cal_done <= 1'b0;
    @(posedge CLK);
    chk("engine", {2'h0, coefs[70+:14]}, {2'h0, v[0][13:0]});
    cmd(1'b0, 1'b0, 16'h0000, 16'h00c0);
    for (int s = 0; s < 4; s++) begin
      n = (s == 0) ? 10 : (s == 1) ? 2 : 1;
      c = 16'h0080 | 16'(s << 1);
      cmd(1'b1, 1'b0, c, 16'h0000);
      for (int k = 0; k < n; k++) begin
        v[k] = 16'($urandom);
        cmd(1'b1, 1'b1, v[k], 16'h0000);
        x = (s == 2) ? 1 : k;
        chk("coef", {2'h0, coefs[x*14+:14]}, {2'h0, v[k][13:0]});
      end
      cmd(1'b1, 1'b0, c, 16'h0000);
      // one read past the set shows the wrap to its first register
      for (int k = 0; k <= n; k++) cmd(1'b0, 1'b0, 16'h0000, {2'h0, v[k % n][13:0]});
    end
    cmd(1'b1, 1'b0, 16'h0080, 16'h0000);
    cmd(1'b1, 1'b1, v[5], 16'h0000);
    cmd(1'b1, 1'b1, v[6], 16'h0000);
    cmd(1'b1, 1'b0, 16'h0080, 16'h0000);
    cmd(1'b0, 1'b0, 16'h0000, {2'h0, v[5][13:0]});
    // byte lanes: low byte first, pointer steps on the high byte
    byte_mode <= 1'b1;
    cmd(1'b1, 1'b0, 16'h0082, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      v[k] = 16'($urandom);
      cmd(1'b1, 1'b1, v[k], 16'h0000);
      chk("byte_coef", {2'h0, coefs[k*14+:14]}, {2'h0, v[k][13:0]});
    end
    cmd(1'b1, 1'b0, 16'h0082, 16'h0000);
    for (int k = 0; k < 2; k++) cmd(1'b0, 1'b0, 16'h0000, {2'h0, v[k][13:0]});
    end_sim();
  end
endmodule
`default_nettype wire
